// file: core/port_rx_len_prio_map.sv
// Contract
// - A frame whose byte count exceeds the 14-bit length limit is long.
// - A long frame without errors is counted as oversized.
// - A long frame with CRC, code or alignment error is jabber.
// - The length limit resets to 1518.
// - An IP packet takes the 3-bit priority selected by its DSCP value.
// - A packet priority of zero becomes the lowest header map field.
// - Eight 4-bit transmit block settings reset from 8 in the lowest down to 0 in the highest, skipping 3.
// - Priority 7 is the highest of the eight levels.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module port_rx_len_prio_map
  import rx_len_prio_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [rx_len_prio_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Frame end report from the receive MAC
  input wire logic frame_end,
  input wire logic [13:0] frame_bytes,
  input wire logic frame_crc_err,
  input wire logic frame_code_err,
  input wire logic frame_align_err,
  // Frame class result
  output logic frame_long,
  output logic frame_oversize,
  output logic frame_jabber,
  output logic class_valid,
  // Priority lookup request
  input wire logic prio_req,
  input wire logic prio_is_ip,
  input wire logic [4:0] prio_dscp,
  input wire logic [2:0] prio_pkt,
  // Priority lookup result
  output logic prio_valid,
  output logic [2:0] prio_rx,
  output logic prio_is_top,
  // Transmit block settings
  output logic [31:0] tx_blocks,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic [13:0] maxlen;
    logic [31:0] txblks;
    logic [31:0] dscp0;
    logic [31:0] dscp1;
    logic [31:0] dscp2;
    logic [31:0] dscp3;
    logic [31:0] hdrmap;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [31:0] rdata;
    logic long_f;
    logic over_f;
    logic jab_f;
    logic cvalid;
    logic pvalid;
    logic [2:0] prio;
    logic top;
    logic irq;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [127:0] dscp_all;
  logic [2:0] dscp_field [32];
  logic [2:0] hdr_field [8];

  // ---------------------------------------------------------------
  // Field views
  // ---------------------------------------------------------------
  assign dscp_all = {s_q.dscp3, s_q.dscp2, s_q.dscp1, s_q.dscp0};

  // One 3-bit field per nibble, lowest value lowest
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_dscp
      assign dscp_field[gi] = dscp_all[gi*NIB_W +: PRIO_W];
    end
    for (gi = 0; gi < 8; gi++) begin : g_hdr
      assign hdr_field[gi] = s_q.hdrmap[gi*NIB_W +: PRIO_W];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic is_long;
    logic has_err;
    logic [2:0] pri;
    logic [1:0] ev;
    is_long = frame_bytes > s_q.maxlen;
    has_err = frame_crc_err | frame_code_err | frame_align_err;
    pri = prio_pkt;
    ev = 2'h0;
    s_d = s_q;
    s_d.rdata = 32'h0000_0000;
    s_d.cvalid = frame_end;
    s_d.pvalid = prio_req;

    // Length classing on each frame end
    if (frame_end) begin
      s_d.long_f = is_long;
      s_d.over_f = is_long & ~has_err;
      s_d.jab_f = is_long & has_err;
      ev[IRQ_OVERSIZE] = is_long & ~has_err;
      ev[IRQ_JABBER] = is_long & has_err;
    end

    // Priority lookup; zero remap only for non-IP packets
    if (prio_req) begin
      if (prio_is_ip) begin
        pri = dscp_field[prio_dscp];
      end else if (prio_pkt == PRIO_ZERO) begin
        pri = hdr_field[0];
      end else begin
        pri = hdr_field[prio_pkt];
      end
      s_d.prio = pri;
      s_d.top = (pri == PRIO_HIGHEST);
    end

    // Register writes, reserved bits masked off
    if (reg_wr) begin
      case (reg_addr[5:2])
        REG_MAXLEN: s_d.maxlen = reg_wdata[MAXLEN_W-1:0];
        REG_TXBLKS: s_d.txblks = reg_wdata;
        REG_DSCP0: s_d.dscp0 = reg_wdata & PRIO_FIELD_MASK;
        REG_DSCP1: s_d.dscp1 = reg_wdata & PRIO_FIELD_MASK;
        REG_DSCP2: s_d.dscp2 = reg_wdata & PRIO_FIELD_MASK;
        REG_DSCP3: s_d.dscp3 = reg_wdata & PRIO_FIELD_MASK;
        REG_HDRMAP: s_d.hdrmap = reg_wdata & PRIO_FIELD_MASK;
        REG_IRQ_STAT: s_d.stat = s_q.stat & ~reg_wdata[IRQ_W-1:0];
        REG_IRQ_MASK: s_d.mask = reg_wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    // Set wins over a same-cycle clear
    s_d.stat = s_d.stat | ev;

    // Read data, one cycle after the strobe; unmapped reads zero
    if (reg_rd) begin
      case (reg_addr[5:2])
        REG_MAXLEN: s_d.rdata = {18'h00000, s_q.maxlen};
        REG_TXBLKS: s_d.rdata = s_q.txblks;
        REG_DSCP0: s_d.rdata = s_q.dscp0;
        REG_DSCP1: s_d.rdata = s_q.dscp1;
        REG_DSCP2: s_d.rdata = s_q.dscp2;
        REG_DSCP3: s_d.rdata = s_q.dscp3;
        REG_HDRMAP: s_d.rdata = s_q.hdrmap;
        REG_IRQ_STAT: s_d.rdata = {30'h00000000, s_q.stat};
        REG_IRQ_MASK: s_d.rdata = {30'h00000000, s_q.mask};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    s_d.irq = |(s_d.stat & s_d.mask);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.maxlen <= MAXLEN_RST;
      s_q.txblks <= TXBLKS_RST;
      s_q.hdrmap <= HDRMAP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops
  assign reg_rdata = s_q.rdata;
  assign frame_long = s_q.long_f;
  assign frame_oversize = s_q.over_f;
  assign frame_jabber = s_q.jab_f;
  assign class_valid = s_q.cvalid;
  assign prio_valid = s_q.pvalid;
  assign prio_rx = s_q.prio;
  assign prio_is_top = s_q.top;
  assign tx_blocks = s_q.txblks;
  assign irq = s_q.irq;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Count and limit are both the ones seen at the frame end edge
  long_class_a: assert property (
    @(posedge clk) disable iff (!rstn)
    frame_end
    |=> frame_long == ($past(frame_bytes) > $past(s_q.maxlen)))
    else $error("long frame class wrong");

  oversize_class_a: assert property (
    @(posedge clk) disable iff (!rstn)
    class_valid |-> frame_oversize == (frame_long && !frame_jabber))
    else $error("oversize class wrong");

  jabber_excl_a: assert property (
    @(posedge clk) disable iff (!rstn)
    frame_end && (frame_bytes > s_q.maxlen) && frame_crc_err
    |=> frame_jabber && !frame_oversize)
    else $error("jabber class wrong");

  dscp_lookup_a: assert property (
    @(posedge clk) disable iff (!rstn)
    prio_req && prio_is_ip |=> prio_rx == $past(dscp_field[prio_dscp]))
    else $error("dscp priority wrong");

  zero_remap_a: assert property (
    @(posedge clk) disable iff (!rstn)
    prio_req && !prio_is_ip && prio_pkt == PRIO_ZERO
    |=> prio_rx == $past(s_q.hdrmap[2:0]))
    else $error("zero priority remap wrong");

  top_prio_a: assert property (
    @(posedge clk) disable iff (!rstn)
    prio_valid |-> prio_is_top == (prio_rx == PRIO_HIGHEST))
    else $error("top priority flag wrong");

  txblk_write_a: assert property (
    @(posedge clk) disable iff (!rstn)
    reg_wr && reg_addr[5:2] == REG_TXBLKS
    |=> tx_blocks == $past(reg_wdata))
    else $error("tx block write lost");

  reserved_zero_a: assert property (
    @(posedge clk) disable iff (!rstn)
    reg_rd && reg_addr[5:2] == REG_MAXLEN |=> reg_rdata[31:14] == 18'h00000)
    else $error("reserved bits not zero");

  irq_level_a: assert property (
    @(posedge clk) disable iff (!rstn)
    irq == |(s_q.stat & s_q.mask))
    else $error("interrupt level wrong");

  // ---------------------------------------------------------------
  // Class, map and strobe timing checks
  // ---------------------------------------------------------------

  // Code and align errors count as much as a CRC error
  long_jabber_a: assert property (
    @(posedge clk) disable iff (!rstn)
    frame_end && (frame_bytes > s_q.maxlen)
    && (frame_code_err || frame_align_err)
    |=> frame_jabber && !frame_oversize)
    else $error("code or align jabber wrong");

  clean_oversize_a: assert property (
    @(posedge clk) disable iff (!rstn)
    frame_end && (frame_bytes > s_q.maxlen) && !frame_crc_err
    && !frame_code_err && !frame_align_err
    |=> frame_oversize && !frame_jabber)
    else $error("clean long frame not oversize");

  // A frame exactly at the limit is still a normal frame
  short_frame_a: assert property (
    @(posedge clk) disable iff (!rstn)
    frame_end && (frame_bytes <= s_q.maxlen)
    |=> !frame_long && !frame_oversize && !frame_jabber)
    else $error("short frame marked long");

  limit_write_a: assert property (
    @(posedge clk) disable iff (!rstn)
    reg_wr && reg_addr[5:2] == REG_MAXLEN
    |=> s_q.maxlen == $past(reg_wdata[MAXLEN_W-1:0]))
    else $error("length limit write lost");

  map_reserved_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (dscp_all & {4{~PRIO_FIELD_MASK}}) == 128'h0
    && (s_q.hdrmap & ~PRIO_FIELD_MASK) == 32'h0)
    else $error("reserved map bits set");

  // Clear and event in one cycle: losing the event would hide it
  jab_set_wins_a: assert property (
    @(posedge clk) disable iff (!rstn)
    frame_end && (frame_bytes > s_q.maxlen)
    && (frame_crc_err || frame_code_err || frame_align_err)
    |=> s_q.stat[IRQ_JABBER])
    else $error("jabber status lost");

  prio_hold_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !prio_req |=> $stable(prio_rx) && !prio_valid)
    else $error("priority result moved");

  rdata_idle_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");

  frame_pulse_a: assert property (
    @(posedge clk) disable iff (!rstn)
    class_valid == $past(frame_end))
    else $error("class valid not one cycle");

endmodule : port_rx_len_prio_map

`default_nettype wire

// file: core/rx_len_prio_pkg.sv
package rx_len_prio_pkg;

  // ---------------------------------------------------------------
  // Register map (word index, byte address is four times it)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_MAXLEN = 4'h0;
  localparam logic [3:0] REG_TXBLKS = 4'h1;
  localparam logic [3:0] REG_DSCP0 = 4'h2;
  localparam logic [3:0] REG_DSCP1 = 4'h3;
  localparam logic [3:0] REG_DSCP2 = 4'h4;
  localparam logic [3:0] REG_DSCP3 = 4'h5;
  localparam logic [3:0] REG_HDRMAP = 4'h6;
  localparam logic [3:0] REG_IRQ_STAT = 4'h7;
  localparam logic [3:0] REG_IRQ_MASK = 4'h8;
  localparam int ADDR_W = 6;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int MAXLEN_W = 14;
  localparam logic [13:0] MAXLEN_RST = 14'h05ee;
  localparam logic [13:0] MAXLEN_LIMIT = 14'h2584;
  localparam logic [31:0] TXBLKS_RST = 32'h0124_5678;
  localparam logic [31:0] HDRMAP_RST = 32'h7654_3210;
  localparam logic [31:0] PRIO_FIELD_MASK = 32'h7777_7777;
  localparam int PRIO_W = 3;
  localparam int NIB_W = 4;
  localparam logic [2:0] PRIO_HIGHEST = 3'h7;
  localparam logic [2:0] PRIO_ZERO = 3'h0;

  // Interrupt status bits
  localparam int IRQ_OVERSIZE = 0;
  localparam int IRQ_JABBER = 1;
  localparam int IRQ_W = 2;

endpackage : rx_len_prio_pkg

// file: verif/frame_src.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Frame source
// ----
module frame_src (
  // Clock
  input wire logic clk,
  // Frame report
  output logic frame_end,
  output logic [13:0] frame_bytes,
  output logic [2:0] errs
);
  // Quiet at time zero
  initial begin
    {frame_end, frame_bytes, errs} = 18'h0;
  end
  // Idle lines flip so a stale count never looks valid
  task automatic send(input logic [13:0] b, input logic [2:0] e);
    @(posedge clk);
    {frame_end, frame_bytes, errs} <= {1'b1, b, e};
    @(posedge clk);
    {frame_end, frame_bytes, errs} <= {1'b0, ~b, ~e};
  endtask : send
endmodule : frame_src
`default_nettype wire

// file: verif/port_rx_len_prio_map_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench top
// ----
module port_rx_len_prio_map_tb_top;
  import rx_len_prio_pkg::*;
  logic clk, rstn, reg_wr, reg_rd, prio_req, prio_is_ip, irq;
  logic frame_end, frame_long, frame_oversize, frame_jabber;
  logic class_valid, prio_valid, prio_is_top;
  logic [5:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, tx_blocks, v;
  logic [31:0] map [0:4];
  logic [13:0] frame_bytes, lim;
  logic [2:0] errs, prio_rx, prio_pkt;
  logic [4:0] prio_dscp;
  int n_errors, samples_checked, cyc, seed, i;

  // Errors from the source: crc, code, align
  port_rx_len_prio_map dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .frame_end(frame_end),
    .frame_bytes(frame_bytes), .frame_crc_err(errs[0]),
    .frame_code_err(errs[1]), .frame_align_err(errs[2]),
    .frame_long(frame_long), .frame_oversize(frame_oversize),
    .frame_jabber(frame_jabber), .class_valid(class_valid),
    .prio_req(prio_req), .prio_is_ip(prio_is_ip), .prio_dscp(prio_dscp),
    .prio_pkt(prio_pkt), .prio_valid(prio_valid), .prio_rx(prio_rx),
    .prio_is_top(prio_is_top), .tx_blocks(tx_blocks), .irq(irq));
  frame_src src (.clk(clk), .frame_end(frame_end),
    .frame_bytes(frame_bytes), .errs(errs));

  // Expected long, oversize, jabber
  function automatic logic [2:0] cls(logic [13:0] b, logic [2:0] e);
    cls[2] = b > lim;
    cls[1] = cls[2] && e == 3'h0;
    cls[0] = cls[2] && e != 3'h0;
  endfunction : cls
  // Expected priority from the map copies
  function automatic logic [2:0] pri(logic ip, logic [4:0] d,
                                     logic [2:0] p);
    if (ip)
      return map[d[4:3]][d[2:0]*4 +: 3];
    return map[4][p*4 +: 3];
  endfunction : pri
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(logic [5:0] a, logic [31:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rdc(logic [5:0] a, logic [31:0] e);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, e);
  endtask : rdc
  task automatic fr(logic [13:0] b, logic [2:0] e);
    src.send(b, e);
    #1 chk("class", {class_valid, frame_long, frame_oversize,
      frame_jabber}, {1'b1, cls(b, e)});
  endtask : fr
  task automatic look(logic ip, logic [4:0] d, logic [2:0] p);
    logic [2:0] e;
    e = pri(ip, d, p);
    @(posedge clk);
    {prio_req, prio_is_ip, prio_dscp, prio_pkt} <= {1'b1, ip, d, p};
    @(posedge clk);
    prio_req <= 1'b0;
    #1 chk("prio", {prio_valid, prio_is_top, prio_rx},
      {1'b1, e == 3'h7, e});
  endtask : look
  task automatic end_sim();
    $display("checked %0d bad %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  // Main sequence
  initial begin
    seed = 40087;
    {rstn, reg_wr, reg_rd, prio_req, prio_is_ip} = 5'h0;
    {reg_addr, reg_wdata, prio_dscp, prio_pkt} = 46'h0;
    for (i = 0; i < 4; i++) map[i] = 32'h0;
    map[4] = 32'h7654_3210;
    lim = 14'd1518;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rdc(6'h00, 32'h0000_05ee);
    rdc(6'h04, 32'h0124_5678);
    chk("tx_blocks", tx_blocks, 32'h0124_5678);
    rdc(6'h14, 32'h0);
    $display("reset done");
    for (i = 0; i < 8; i++) fr(14'd1518 + i[0], i[2:0]);
    // Reserved bits set, field kept within what software may program
    wr(6'h00, {18'h3ffff, MAXLEN_LIMIT});
    wr(6'h3c, 32'hffff_ffff);
    rdc(6'h00, {18'h0, MAXLEN_LIMIT});
    rdc(6'h3c, 32'h0);
    // Limits stay within what software may program
    repeat (6) begin
      lim = 14'd2 + 14'($unsigned($random(seed)) % 9603);
      wr(6'h00, {18'h0, lim});
      repeat (6) fr(lim + 14'($random(seed) & 3) - 14'd2, 3'($random(seed)));
    end
    $display("length done");
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      wr({REG_TXBLKS + i[3:0], 2'b00}, v);
      rdc({REG_TXBLKS + i[3:0], 2'b00}, i == 0 ? v : v & 32'h7777_7777);
      if (i == 0) chk("tx_blocks", tx_blocks, v);
      if (i > 0) map[i - 1] = v & 32'h7777_7777;
    end
    look(1'b0, 5'h0, 3'h0);
    look(1'b1, 5'h1f, 3'h0);
    repeat (40) look(1'($random(seed)), 5'($random(seed)), 3'($random(seed)));
    $display("priority done");
    lim = 14'd100;
    wr(6'h00, 32'd100);
    wr(6'h1c, 32'h3);
    wr(6'h20, 32'h2);
    fr(14'd200, 3'h0);
    @(posedge clk);
    #1 chk("irq", 32'(irq), 32'h0);
    rdc(6'h1c, 32'h1);
    fr(14'd200, 3'h4);
    @(posedge clk);
    #1 chk("irq", 32'(irq), 32'h1);
    wr(6'h1c, 32'h3);
    @(posedge clk);
    #1 chk("irq", 32'(irq), 32'h0);
    // Clear and event in one cycle: the event must survive
    fork
      wr(6'h1c, 32'h3);
      fr(14'd200, 3'h1);
    join
    rdc(6'h1c, 32'h2);
    chk("irq", 32'(irq), 32'h1);
    $display("irq done");
    // Second reset in mid-run; settings fall back at once
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    #1 chk("tx_blocks", tx_blocks, TXBLKS_RST);
    @(posedge clk);
    rstn <= 1'b1;
    rdc(6'h00, {18'h0, MAXLEN_RST});
    rdc(6'h18, HDRMAP_RST);
    map[4] = HDRMAP_RST;
    look(1'b0, 5'h0, 3'h7);
    $display("second reset done");
    end_sim();
  end
endmodule : port_rx_len_prio_map_tb_top
`default_nettype wire
